// file: rtl/cg_clock_gen.sv
// clock generator: reference monitor, loop, source select, divider
//
// Added by the designer: the address map and strobed register access.
`timescale 1ns/1ns
`default_nettype none
//
// Contract
// - reset comes up self-clocked, loop open, oscillator free running
// - self-clocked frequency set only by filter bits, no comparison
// - off mode holds output clock static; entered on stop
// - engaged internal multiplies internal reference, unlocked then locked
// - bypassed external routes external clock straight to output
// - engaged external multiplies external reference, unlocked then locked
// - status shows lock and later loss of lock
// - external reference monitored and its validity flagged
// - engaged with lost lock or clock adds extra halving
// - loss of clock or lock gives reset or interrupt, selectable
// - post divider picks power of two from 1 to 128
// - oscillator setting kept across deep stop for fast relock
// - oscillator keeps present frequency when reference disappears
// - switch to loop output only after lock
// - refuse any clock source that is not running
// - loop band 8 to 40 MHz, bus up to half of top
// - 8 MHz debug clock and trimmable 243 kHz reference
// - two crystal ranges, low and high, software selected
// - high gain select picks low power or high amplitude
// - fixed frequency enable gates fixed system clock
// - separate self-clocked source drives real-time interrupt
module cg_clock_gen #(
	parameter int TMO_LO = cg_pkg::TMO_LO_CYC,
	parameter int RTI_CYCLES = cg_pkg::RTI_CYC
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr_stb,
	input  wire logic       i_rd_stb,
	output logic [7:0]      o_rdata,
	input  wire logic       i_ext_ref,
	input  wire logic       i_stop,
	output logic            o_generator_output_clock,
	output logic            o_bus_clk_en,
	output logic            o_loop_multiplied_clock_en,
	output logic            o_external_reference_clock_en,
	output logic            o_debug_local_clock_en,
	output logic            o_fixed_system_clock_en,
	output logic            o_rti_clk_en,
	output logic            o_osc_range_high,
	output logic            o_osc_high_gain,
	output logic            o_locked,
	output logic            o_ref_valid,
	output logic            o_loss_reset,
	output logic            o_loss_irq
);
	logic [7:0]  ctrl_q;
	logic [6:0]  mult_q;
	logic [13:0] filter_q;
	logic [2:0]  div_q;
	logic [7:0]  trim_q;
	logic        rti_en_q;
	logic        ext_s1_q, ext_s2_q, ext_s3_q;
	logic [15:0] acc_q;
	logic        osc_tick_q;
	logic [7:0]  win_q;
	logic [1:0]  lock_cnt_q;
	logic        locked_q, locked_p_q;
	logic [17:0] mon_q;
	logic        ref_valid_q, ref_valid_p_q;
	logic        lol_q, loc_q;
	cg_pkg::cg_src_t src_q, src_req;
	logic [2:0]  div_act_q;
	logic        half_act_q;
	logic [8:0]  cnt_q;
	logic        out_q, fix_ph_q;
	logic        iref_tick;

	// register decode
	wire wr_ctrl = i_wr_stb && (i_addr == cg_pkg::REG_CTRL);
	wire wr_mult = i_wr_stb && (i_addr == cg_pkg::REG_MULT);
	wire wr_flo  = i_wr_stb && (i_addr == cg_pkg::REG_FILT_LO);
	wire wr_fhi  = i_wr_stb && (i_addr == cg_pkg::REG_FILT_HI);
	wire wr_div  = i_wr_stb && (i_addr == cg_pkg::REG_DIV);
	wire wr_trim = i_wr_stb && (i_addr == cg_pkg::REG_TRIM);
	wire wr_stat = i_wr_stb && (i_addr == cg_pkg::REG_STAT);
	wire wr_rti  = i_wr_stb && (i_addr == cg_pkg::REG_RTI);
	wire wr_filt = wr_flo || wr_fhi;

	wire cg_pkg::cg_mode_t mode = cg_pkg::cg_mode_t'(
		ctrl_q[cg_pkg::CTRL_MODE_LSB +: 2]);
	wire range_hi = ctrl_q[cg_pkg::CTRL_RANGE];
	wire fix_en   = ctrl_q[cg_pkg::CTRL_FIX_EN];
	wire loss_rst = ctrl_q[cg_pkg::CTRL_LOSS_RST];
	wire eng_mode = (mode == cg_pkg::MODE_ENG_INT) ||
		(mode == cg_pkg::MODE_ENG_EXT);
	wire ext_mode = (mode == cg_pkg::MODE_BYP_EXT) ||
		(mode == cg_pkg::MODE_ENG_EXT);

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q   <= cg_pkg::CTRL_RST;
			mult_q   <= cg_pkg::MULT_RST;
			div_q    <= cg_pkg::DIV_RST;
			trim_q   <= cg_pkg::TRIM_RST;
			rti_en_q <= 1'b0;
		end else begin
			if (wr_ctrl)
				ctrl_q <= i_wdata;
			if (wr_mult)
				mult_q <= i_wdata[6:0];
			if (wr_div)
				div_q <= i_wdata[2:0];
			if (wr_trim)
				trim_q <= i_wdata;
			if (wr_rti)
				rti_en_q <= i_wdata[0];
		end
	end

	// external reference pin, synchronised before use
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			ext_s1_q <= i_ext_ref;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end
	wire ext_edge = ext_s2_q && !ext_s3_q;

	// reference monitor: timeout follows the crystal range
	wire [17:0] tmo = range_hi ? 18'(cg_pkg::TMO_HI_CYC) : 18'(TMO_LO);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mon_q         <= '1;
			ref_valid_q   <= 1'b0;
			ref_valid_p_q <= 1'b0;
		end else begin
			if (ext_edge)
				mon_q <= '0;
			else if (mon_q != '1)
				mon_q <= mon_q + 18'h1;
			ref_valid_q   <= (mon_q < tmo);
			ref_valid_p_q <= ref_valid_q;
		end
	end

	// controlled oscillator as a phase accumulator
	wire [16:0] acc_sum = {1'b0, acc_q} + {3'h0, filter_q};
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			acc_q      <= '0;
			osc_tick_q <= 1'b0;
		end else begin
			acc_q      <= acc_sum[15:0];
			osc_tick_q <= acc_sum[16];
		end
	end

	// internal references and the real-time interrupt source
	wire [17:0] iref_per = 18'(cg_pkg::IREF_CYC) + {10'h0, trim_q} -
		{10'h0, cg_pkg::TRIM_MID};
	cg_tick_div #(.W(18)) u_iref (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_en     (1'b1),
		.i_period (iref_per),
		.o_tick   (iref_tick)
	);
	cg_tick_div #(.W(18)) u_dbg (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_en     (1'b1),
		.i_period (18'(cg_pkg::DBG_CYC)),
		.o_tick   (o_debug_local_clock_en)
	);
	// free of the oscillator so the interrupt runs in any mode
	cg_tick_div #(.W(18)) u_rti (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_en     (rti_en_q),
		.i_period (18'(RTI_CYCLES)),
		.o_tick   (o_rti_clk_en)
	);

	// loop: count oscillator ticks per reference period
	wire loop_run = (mode == cg_pkg::MODE_ENG_INT) ||
		((mode == cg_pkg::MODE_ENG_EXT) && ref_valid_q);
	wire ref_tick = (mode == cg_pkg::MODE_ENG_INT) ? iref_tick : ext_edge;
	wire eval     = loop_run && ref_tick;
	wire [8:0] tgt = {2'b00, mult_q};
	wire [8:0] win = {1'b0, win_q};
	wire slow     = win < tgt;
	wire [7:0] emag = slow ? 8'(tgt - win) : 8'(win - tgt);
	wire near     = emag <= 8'(cg_pkg::LOCK_TOL);
	wire far      = emag > 8'(cg_pkg::UNLOCK_TOL);
	wire [14:0] step = {2'b00, emag, 5'h0} >> (5 - cg_pkg::STEP_SH);
	wire [14:0] f_up = {1'b0, filter_q} + step;
	wire [14:0] f_dn = {1'b0, filter_q} - step;
	wire [13:0] f_hi = (f_up > {1'b0, cg_pkg::FILT_MAX}) ?
		cg_pkg::FILT_MAX : f_up[13:0];
	wire [13:0] f_lo = (f_dn[14] || f_dn < {1'b0, cg_pkg::FILT_MIN}) ?
		cg_pkg::FILT_MIN : f_dn[13:0];

	// filter is reset only by i_rst, so stop leaves the setting intact
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			filter_q <= cg_pkg::FILT_RST;
		else if (wr_flo)
			filter_q[7:0] <= i_wdata;
		else if (wr_fhi)
			filter_q[13:8] <= i_wdata[5:0];
		else if (eval && !near)
			filter_q <= slow ? f_hi : f_lo;
	end

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			win_q      <= '0;
			lock_cnt_q <= '0;
			locked_q   <= 1'b0;
			locked_p_q <= 1'b0;
		end else begin
			locked_p_q <= locked_q;
			if (ref_tick)
				win_q <= 8'(osc_tick_q);
			else if (osc_tick_q && win_q != 8'hff)
				win_q <= win_q + 8'h1;
			if (!loop_run) begin
				locked_q   <= 1'b0;
				lock_cnt_q <= '0;
			end else if (eval && near) begin
				if (lock_cnt_q == 2'(cg_pkg::LOCK_WIN - 1))
					locked_q <= 1'b1;
				else
					lock_cnt_q <= lock_cnt_q + 2'h1;
			end else if (eval && far) begin
				locked_q   <= 1'b0;
				lock_cnt_q <= '0;
			end
		end
	end

	// sticky loss flags, write one to clear, a new loss wins
	wire lol_set = locked_p_q && !locked_q;
	wire loc_set = ref_valid_p_q && !ref_valid_q && ext_mode;
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lol_q <= 1'b0;
			loc_q <= 1'b0;
		end else begin
			lol_q <= lol_set ||
				(lol_q && !(wr_stat && i_wdata[cg_pkg::STAT_LOL]));
			loc_q <= loc_set ||
				(loc_q && !(wr_stat && i_wdata[cg_pkg::STAT_LOC]));
		end
	end
	wire half_en = eng_mode && (lol_q || loc_q);

	// requested source; a dead source is never taken
	always_comb begin
		src_req = cg_pkg::SRC_OSC;
		if (i_stop)
			src_req = cg_pkg::SRC_OFF;
		else
			case (mode)
			cg_pkg::MODE_SELF:
				src_req = cg_pkg::SRC_OSC;
			cg_pkg::MODE_ENG_INT:
				if (locked_q)
					src_req = cg_pkg::SRC_LOOP;
			cg_pkg::MODE_BYP_EXT:
				if (ref_valid_q)
					src_req = cg_pkg::SRC_EXT;
			cg_pkg::MODE_ENG_EXT:
				if (locked_q && ref_valid_q)
					src_req = cg_pkg::SRC_LOOP;
			default:
				src_req = cg_pkg::SRC_OSC;
			endcase
	end

	// post divider; source and divisor change only on a falling edge or while the source is off
	wire tick_sel = (src_q == cg_pkg::SRC_EXT) ? ext_edge :
		(src_q == cg_pkg::SRC_OFF) ? 1'b0 : osc_tick_q;
	wire [8:0] lim = half_act_q ? (9'h2 << div_act_q) :
		(9'h1 << div_act_q);
	wire at_lim = (cnt_q == lim - 9'h1);
	wire safe = (src_q == cg_pkg::SRC_OFF) || (tick_sel && at_lim && out_q);
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			src_q        <= cg_pkg::SRC_OSC;
			div_act_q    <= cg_pkg::DIV_RST;
			half_act_q   <= 1'b0;
			cnt_q        <= '0;
			out_q        <= 1'b0;
			o_bus_clk_en <= 1'b0;
		end else begin
			if (safe) begin
				src_q      <= src_req;
				div_act_q  <= div_q;
				half_act_q <= half_en;
			end
			o_bus_clk_en <= tick_sel && at_lim && !out_q;
			if (src_q == cg_pkg::SRC_OFF)
				cnt_q <= '0;
			else if (tick_sel) begin
				cnt_q <= at_lim ? '0 : cnt_q + 9'h1;
				if (at_lim)
					out_q <= !out_q;
			end
		end
	end
	assign o_generator_output_clock = out_q;

	// fixed system clock: external reference halved, gated
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			fix_ph_q                      <= 1'b0;
			o_fixed_system_clock_en       <= 1'b0;
			o_loop_multiplied_clock_en    <= 1'b0;
			o_external_reference_clock_en <= 1'b0;
		end else begin
			if (ext_edge)
				fix_ph_q <= !fix_ph_q;
			o_fixed_system_clock_en <= fix_en && ext_edge && fix_ph_q;
			o_loop_multiplied_clock_en    <= osc_tick_q;
			o_external_reference_clock_en <= ext_edge;
		end
	end

	// read port, data in the cycle after the strobe
	wire [7:0] stat = {1'b0, 2'(src_q), half_act_q, loc_q, ref_valid_q,
		lol_q, locked_q};
	wire [7:0] rd_mux =
		(i_addr == cg_pkg::REG_CTRL)    ? ctrl_q :
		(i_addr == cg_pkg::REG_MULT)    ? {1'b0, mult_q} :
		(i_addr == cg_pkg::REG_FILT_LO) ? filter_q[7:0] :
		(i_addr == cg_pkg::REG_FILT_HI) ? {2'b00, filter_q[13:8]} :
		(i_addr == cg_pkg::REG_DIV)     ? {5'h0, div_q} :
		(i_addr == cg_pkg::REG_TRIM)    ? trim_q :
		(i_addr == cg_pkg::REG_STAT)    ? stat : {7'h0, rti_en_q};
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			o_rdata <= '0;
		else
			o_rdata <= i_rd_stb ? rd_mux : 8'h00;
	end

	assign o_osc_range_high = range_hi;
	assign o_osc_high_gain  = ctrl_q[cg_pkg::CTRL_HIGH_GAIN];
	assign o_locked         = locked_q;
	assign o_ref_valid      = ref_valid_q;
	assign o_loss_reset     = (lol_q || loc_q) && loss_rst;
	assign o_loss_irq       = (lol_q || loc_q) && !loss_rst;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence seq_lock_drop;
		locked_q ##1 !locked_q;
	endsequence
	sequence seq_ref_drop;
		ref_valid_q && ext_mode ##1 !ref_valid_q && ext_mode;
	endsequence

	AST_OFF_STATIC: assert property (
		src_q == cg_pkg::SRC_OFF |=> $stable(out_q) && !out_q)
		else $error("output clock moved while off");
	AST_NO_RUNT: assert property (
		$changed(src_q) |-> !out_q &&
			($past(out_q) || $past(src_q) == cg_pkg::SRC_OFF))
		else $error("source switched while clock high");
	AST_LOOP_AFTER_LOCK: assert property (
		$changed(src_q) && src_q == cg_pkg::SRC_LOOP |-> $past(locked_q))
		else $error("loop selected without lock");
	AST_REFUSE_DEAD: assert property (
		$changed(src_q) && src_q == cg_pkg::SRC_EXT |-> $past(ref_valid_q))
		else $error("dead external source selected");
	AST_SELF_OPEN: assert property (
		mode == cg_pkg::MODE_SELF && !wr_filt |=> $stable(filter_q))
		else $error("filter moved in self-clocked mode");
	AST_HOLD_ON_LOSS: assert property (
		!loop_run && !wr_filt |=> $stable(filter_q))
		else $error("oscillator setting moved without reference");
	AST_LOL_FLAG: assert property (
		seq_lock_drop |=> lol_q [*2])
		else $error("loss of lock not flagged");
	AST_LOC_FLAG: assert property (
		seq_ref_drop |=> loc_q)
		else $error("loss of clock not flagged");
	AST_HALVING: assert property (
		eng_mode && (lol_q || loc_q) && safe |=> half_act_q)
		else $error("extra halving missing after loss");
	AST_LOSS_ROUTE: assert property (
		lol_set |=> ##1 (o_loss_reset == loss_rst) && (o_loss_irq != loss_rst))
		else $error("loss routed to wrong output");
	AST_RESET_DIV: assert property (
		src_q != cg_pkg::SRC_OFF && !half_act_q |-> cnt_q < (9'h1 << div_act_q))
		else $error("divider count beyond selected divisor");
endmodule
`default_nettype wire

// file: rtl/cg_pkg.sv
// package: constants, register map and types of the clock generator
package cg_pkg;
	localparam int CLK_HZ  = 250_000_000;
	localparam int CLK_MHZ = 250;
	localparam int DW = 8;
	localparam int AW = 3;
	// register indices
	localparam logic [2:0] REG_CTRL    = 3'h0;
	localparam logic [2:0] REG_MULT    = 3'h1;
	localparam logic [2:0] REG_FILT_LO = 3'h2;
	localparam logic [2:0] REG_FILT_HI = 3'h3;
	localparam logic [2:0] REG_DIV     = 3'h4;
	localparam logic [2:0] REG_TRIM    = 3'h5;
	localparam logic [2:0] REG_STAT    = 3'h6;
	localparam logic [2:0] REG_RTI     = 3'h7;
	// control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_RANGE    = 2;
	localparam int CTRL_HIGH_GAIN = 3;
	localparam int CTRL_FIX_EN    = 4;
	localparam int CTRL_LOSS_RST = 5;
	// status fields
	localparam int STAT_LOCK     = 0;
	localparam int STAT_LOL      = 1;
	localparam int STAT_REFV     = 2;
	localparam int STAT_LOC      = 3;
	localparam int STAT_HALF     = 4;
	localparam int STAT_SRC_LSB  = 5;
	// reset values
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [6:0]  MULT_RST = 7'h20;
	localparam logic [13:0] FILT_RST = 14'h1000;
	localparam logic [2:0]  DIV_RST  = 3'h0;
	localparam logic [7:0]  TRIM_RST = 8'h80;
	localparam logic [7:0]  TRIM_MID = 8'h80;
	// timing
	localparam int DBG_HZ      = 8_000_000;
	localparam int DBG_CYC     = CLK_HZ / DBG_HZ;
	localparam int IREF_HZ     = 243_000;
	localparam int IREF_CYC    = CLK_HZ / IREF_HZ;
	localparam int RTI_US      = 1000;
	localparam int RTI_CYC     = RTI_US * CLK_MHZ;
	localparam int TMO_HI_NS   = 2000;
	localparam int TMO_HI_CYC  = TMO_HI_NS * CLK_MHZ / 1000;
	localparam int TMO_LO_US   = 100;
	localparam int TMO_LO_CYC  = TMO_LO_US * CLK_MHZ;
	// loop band, as phase increment of a 16-bit accumulator
	localparam int FLL_MIN_HZ  = 8_000_000;
	localparam int FLL_MAX_HZ  = 40_000_000;
	localparam int ACC_HZ      = CLK_HZ / 65536;
	localparam logic [13:0] FILT_MIN = 14'(FLL_MIN_HZ / ACC_HZ);
	localparam logic [13:0] FILT_MAX = 14'(FLL_MAX_HZ / ACC_HZ);
	localparam int LOCK_TOL    = 1;
	localparam int UNLOCK_TOL  = 4;
	localparam int LOCK_WIN    = 3;
	localparam int STEP_SH     = 5;
	typedef enum logic [1:0] {
		MODE_SELF, MODE_ENG_INT, MODE_BYP_EXT, MODE_ENG_EXT
	} cg_mode_t;
	typedef enum logic [1:0] {SRC_OFF, SRC_OSC, SRC_EXT, SRC_LOOP} cg_src_t;
endpackage

// file: rtl/cg_tick_div.sv
// periodic one-cycle tick from a programmable cycle count
`timescale 1ns/1ns
`default_nettype none
module cg_tick_div #(
	parameter int W = 18
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst,
	input  wire logic         i_en,
	input  wire logic [W-1:0] i_period,
	output logic              o_tick
);
	logic [W-1:0] cnt_q;
	wire          wrap = (cnt_q >= i_period - W'(1));

	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end else if (!i_en) begin
			cnt_q  <= '0;
			o_tick <= 1'b0;
		end else begin
			cnt_q  <= wrap ? '0 : cnt_q + W'(1);
			o_tick <= wrap;
		end
	end
endmodule
`default_nettype wire

// file: tb/cg_ext_src.sv
// partner model: crystal or external square wave at the reference pin
`timescale 1ns/1ns
`default_nettype none
module cg_ext_src #(
	parameter int HALF_NS = 402
) (
	input  wire logic i_run,
	output logic      o_ref
);
	// half period of 402 ns, not a whole number of core clock periods, keeps the pin unrelated in phase to the core clock
	// rate kept low so any configured loop stays under its cap
	always begin
		if (i_run === 1'b1) begin
			#(HALF_NS) o_ref = ~o_ref;
		end else begin
			// a dead source stands still low, it does not keep toggling
			o_ref = 1'b0;
			#1;
		end
	end
endmodule
`default_nettype wire

// file: tb/tb_cg_clock_gen.sv
// self-checking testbench of the clock generator
`timescale 1ns/1ns
`default_nettype none
module tb_cg_clock_gen;
	logic       i_clk, i_rst, i_wr_stb, i_rd_stb, i_stop, ref_run;
	logic [2:0] i_addr;
	logic [7:0] i_wdata, o_rdata, rv;
	logic       i_ext_ref, gen_clk, bus_en, osc_en, ext_en, dbg_en, fix_en;
	logic       rti_en, rng_hi, hgain, locked, ref_ok, loss_rst, loss_irq;
	int         n_fail, samples_checked, n_bus, n_osc, n_ext, n_fix, g;

	cg_clock_gen #(.TMO_LO(200), .RTI_CYCLES(50)) dut (
		.i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rdata(o_rdata),
		.i_ext_ref(i_ext_ref), .i_stop(i_stop),
		.o_generator_output_clock(gen_clk), .o_bus_clk_en(bus_en),
		.o_loop_multiplied_clock_en(osc_en),
		.o_external_reference_clock_en(ext_en),
		.o_debug_local_clock_en(dbg_en), .o_fixed_system_clock_en(fix_en),
		.o_rti_clk_en(rti_en), .o_osc_range_high(rng_hi),
		.o_osc_high_gain(hgain), .o_locked(locked), .o_ref_valid(ref_ok),
		.o_loss_reset(loss_rst), .o_loss_irq(loss_irq));
	cg_ext_src src (.i_run(ref_run), .o_ref(i_ext_ref));

	initial begin
		i_clk = 1'b0;
		forever #2 i_clk = ~i_clk;
	end

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic bad(string m);
		n_fail++;
		$display("FAIL %0t %s", $time, m);
	endtask
	task automatic chk(logic [7:0] got, logic [7:0] exp, string m);
		samples_checked++;
		if (got !== exp) begin
			bad(m);
		end
	endtask
	task automatic near(int got, int exp, int tol, string m);
		samples_checked++;
		if (got < exp - tol || got > exp + tol) begin
			bad(m);
		end
	endtask
	// every bus task leaves one idle cycle so no strobe is set twice at once
	task automatic wr(logic [2:0] a, logic [7:0] d);
		i_addr <= a;
		i_wdata <= d;
		i_wr_stb <= 1'b1;
		@(posedge i_clk);
		i_wr_stb <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(logic [2:0] a);
		i_addr <= a;
		i_rd_stb <= 1'b1;
		@(posedge i_clk);
		i_rd_stb <= 1'b0;
		#1 rv = o_rdata;
		@(posedge i_clk);
	endtask
	task automatic count(int n);
		n_bus = 0;
		n_osc = 0;
		n_ext = 0;
		n_fix = 0;
		repeat (n) begin
			@(posedge i_clk);
			#1;
			if (bus_en === 1'b1) n_bus++;
			if (osc_en === 1'b1) n_osc++;
			if (ext_en === 1'b1) n_ext++;
			if (fix_en === 1'b1) n_fix++;
		end
		@(posedge i_clk);
	endtask
	// which: 0 lock gained, 1 reference valid, 2 reference lost
	task automatic wait_for(int which, int lim);
		int i;
		for (i = 0; i < lim; i++) begin
			@(posedge i_clk);
			if ((which == 0 && locked === 1'b1) ||
			    (which == 1 && ref_ok === 1'b1) ||
			    (which == 2 && ref_ok === 1'b0)) break;
		end
		if (i == lim) begin
			bad("wait ran out");
			print_verdict();
		end
	endtask
	// cycles between two pulses; 300 means none seen
	task automatic gap(logic rti, output int n);
		n = 0;
		repeat (300) begin
			@(posedge i_clk);
			#1;
			if ((rti ? rti_en : dbg_en) === 1'b1) break;
		end
		repeat (300) begin
			@(posedge i_clk);
			#1;
			n++;
			if ((rti ? rti_en : dbg_en) === 1'b1) break;
		end
		@(posedge i_clk);
	endtask

	task automatic t_reset;
		logic [7:0] exp [8] = '{8'h00, 8'h20, 8'h00, 8'h10,
		                        8'h00, 8'h80, 8'h20, 8'h00};
		for (int a = 0; a < 8; a++) begin
			rd(3'(a));
			chk(rv, exp[a], "reset value");
		end
		chk({4'h0, locked, ref_ok, loss_rst, loss_irq}, 8'h00, "reset pins");
	endtask
	task automatic t_pins;
		wr(cg_pkg::REG_CTRL, 8'h0c);
		chk({6'h0, rng_hi, hgain}, 8'h03, "range and gain set");
		wr(cg_pkg::REG_CTRL, 8'h00);
		chk({6'h0, rng_hi, hgain}, 8'h00, "range and gain clear");
		wr(cg_pkg::REG_TRIM, 8'h91);
		rd(cg_pkg::REG_TRIM);
		chk(rv, 8'h91, "trim readback");
		wr(cg_pkg::REG_TRIM, 8'h80);
		gap(1'b0, g);
		near(g, 31, 0, "debug clock period");
		wr(cg_pkg::REG_RTI, 8'h01);
		gap(1'b1, g);
		near(g, 50, 0, "rti clock period");
		wr(cg_pkg::REG_RTI, 8'h00);
		gap(1'b1, g);
		near(g, 300, 0, "rti clock stopped");
	endtask
	task automatic t_filter;
		wr(cg_pkg::REG_FILT_HI, 8'h20);
		count(4096);
		near(n_osc, 512, 2, "oscillator rate at 0x2000");
		wr(cg_pkg::REG_FILT_HI, 8'h10);
		count(4096);
		near(n_osc, 256, 2, "oscillator rate at 0x1000");
	endtask
	task automatic t_div;
		for (int n = 0; n < 8; n++) begin
			wr(cg_pkg::REG_DIV, 8'(n));
			rd(cg_pkg::REG_DIV);
			chk(rv, 8'(n), "divisor readback");
			count(1100);
			count(2048);
			near(n_bus, 64 >> n, 1, "bus edges per divisor");
		end
		wr(cg_pkg::REG_DIV, 8'h00);
		// the slowest divisor may take a whole output period to give way
		count(4200);
	endtask
	task automatic t_stop;
		wr(cg_pkg::REG_FILT_LO, 8'h34);
		i_stop <= 1'b1;
		count(300);
		count(100);
		near(n_bus, 0, 0, "bus edges while off");
		chk({7'h0, gen_clk}, 8'h00, "output held low while off");
		rd(cg_pkg::REG_STAT);
		chk(rv & 8'h60, 8'h00, "source off");
		i_stop <= 1'b0;
		count(300);
		near(n_bus, 9, 3, "bus edges after wake");
		rd(cg_pkg::REG_FILT_LO);
		chk(rv, 8'h34, "filter kept across stop");
		wr(cg_pkg::REG_FILT_LO, 8'h00);
	endtask
	task automatic t_int;
		wr(cg_pkg::REG_MULT, 8'd64);
		wr(cg_pkg::REG_CTRL, 8'h01);
		rd(cg_pkg::REG_STAT);
		chk(rv & 8'h61, 8'h20, "unlocked runs on oscillator");
		wait_for(0, 20000);
		count(100);
		rd(cg_pkg::REG_STAT);
		chk(rv & 8'h61, 8'h61, "locked on loop output");
	endtask
	task automatic t_byp;
		ref_run <= 1'b1;
		// fixed clock enabled only in an external mode
		wr(cg_pkg::REG_CTRL, 8'h16);
		wait_for(1, 2000);
		wr(cg_pkg::REG_STAT, 8'h0a);
		count(400);
		rd(cg_pkg::REG_STAT);
		chk(rv & 8'h6d, 8'h44, "external source valid");
		count(4000);
		near(n_ext, 20, 1, "reference edges");
		near(n_fix, 10, 1, "fixed clock half of reference");
		near(n_bus, 10, 1, "bus follows external clock");
		wr(cg_pkg::REG_CTRL, 8'h06);
		count(2000);
		near(n_fix, 0, 0, "fixed clock gated off");
	endtask
	task automatic t_ext;
		wr(cg_pkg::REG_MULT, 8'd20);
		wr(cg_pkg::REG_CTRL, 8'h07);
		wr(cg_pkg::REG_STAT, 8'h0a);
		rd(cg_pkg::REG_STAT);
		chk({7'h0, rv[0] | (rv[6:5] == 2'b11)}, 8'h00, "not on loop yet");
		wait_for(0, 30000);
		count(200);
		rd(cg_pkg::REG_STAT);
		chk(rv & 8'h7f, 8'h65, "engaged external locked");
		count(2000);
		g = n_osc;
		ref_run <= 1'b0;
		wait_for(2, 1000);
		count(60);
		rd(cg_pkg::REG_STAT);
		chk(rv & 8'h1f, 8'h1a, "loss flags and halving");
		chk({6'h0, loss_rst, loss_irq}, 8'h01, "loss gives interrupt");
		count(2000);
		near(n_osc, g, 6, "oscillator holds frequency");
		rd(cg_pkg::REG_STAT);
		chk(rv & 8'h60, 8'h20, "dead reference not selected");
		wr(cg_pkg::REG_CTRL, 8'h27);
		chk({6'h0, loss_rst, loss_irq}, 8'h02, "loss gives reset");
		wr(cg_pkg::REG_STAT, 8'h0a);
		chk({6'h0, loss_rst, loss_irq}, 8'h00, "loss cleared");
		// halving is dropped only at the next falling edge of the output
		count(100);
		rd(cg_pkg::REG_STAT);
		chk(rv & 8'h1f, 8'h00, "halving removed");
	endtask

	initial begin
		n_fail = 0;
		samples_checked = 0;
		i_rst = 1'b1;
		i_addr = 3'h0;
		i_wdata = 8'h00;
		i_wr_stb = 1'b0;
		i_rd_stb = 1'b0;
		i_stop = 1'b0;
		ref_run = 1'b0;
		repeat (3) @(posedge i_clk);
		i_rst <= 1'b0;
		@(posedge i_clk);
		t_reset();
		t_pins();
		t_filter();
		t_div();
		t_stop();
		t_int();
		t_byp();
		t_ext();
		print_verdict();
	end
endmodule
`default_nettype wire
